// ===== gpen_cfg.svh
/*
 * Holds the register indexes, field positions, reset values and timing
 * constants of the event-notify port.
 * Assumes it is included by bare name from the package and the memory, debounce and port modules.
 */
`ifndef GPEN_CFG_SVH
`define GPEN_CFG_SVH

// ****************************************
// Configuration space indexes.
// ****************************************
`define GPEN_IDX_SEL 8'hF0
`define GPEN_IDX_CFG1 8'hF1
`define GPEN_IDX_ROUTE 8'hF2
`define GPEN_IDX_CFG2 8'hF3

// ****************************************
// Runtime register offsets within the port window.
// ****************************************
`define GPEN_RT_DOUT 2'h0
`define GPEN_RT_DIN 2'h1
`define GPEN_RT_EVEN 2'h2
`define GPEN_RT_EVST 2'h3

// ****************************************
// Field positions.
// ****************************************
`define GPEN_C1_OE 0
`define GPEN_C1_OD 1
`define GPEN_C1_PU 2
`define GPEN_C1_LOCK 3
`define GPEN_C1_LEVEL 4
`define GPEN_C1_POL 5
`define GPEN_C1_DEB 6
`define GPEN_RT_IRQ 0
`define GPEN_RT_SMI 1
`define GPEN_C2_VDDL 4

// ****************************************
// Reset values.
// ****************************************
`define GPEN_RST_SEL 8'h00
`define GPEN_RST_CFG1 8'h00
`define GPEN_RST_ROUTE 8'h01
`define GPEN_RST_CFG2 8'h00
`define GPEN_RST_DOUT 8'hFF
`define GPEN_RST_EVEN 8'h00
`define GPEN_RST_EVST 8'h00

// ****************************************
// Timing.
// ****************************************
`define GPEN_CLK_MHZ 125
`define GPEN_DEB_MS 16
`define GPEN_DEB_CYC (`GPEN_DEB_MS * `GPEN_CLK_MHZ * 1000)

`endif

// ===== gpen_pkg.sv
/*
 * Holds the types shared by the event-notify port modules.
 * Assumes the configuration header is on the include path.
 */
`default_nettype none
`include "gpen_cfg.svh"

package gpen_pkg;

	// One pin's configuration set.
	typedef struct packed {
		logic [7:0] cfg1;
		logic [7:0] route;
		logic [7:0] cfg2;
	} gpen_pincfg_s;

	// Debounce filter states, Gray coded.
	typedef enum logic [1:0] {
		GPEN_DB_STABLE = 2'h0,
		GPEN_DB_COUNT = 2'h1
	} gpen_db_e;

endpackage
`default_nettype wire

// ===== gpen_cfg_mem.sv
/*
 * Holds the eight per-pin configuration sets with a registered read port.
 * Assumes writes come from the same clock domain as the owner.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpen_cfg.svh"

module gpen_cfg_mem (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [2:0] wr_pin,
	input wire logic wr_en,
	input wire gpen_pkg::gpen_pincfg_s wr_data,
	input wire logic [2:0] rd_pin,
	output gpen_pkg::gpen_pincfg_s rd_data,
	output gpen_pkg::gpen_pincfg_s all_cfg [8]
);

	gpen_pkg::gpen_pincfg_s mem_r [8];
	gpen_pkg::gpen_pincfg_s mem_nxt [8];
	gpen_pkg::gpen_pincfg_s rd_r;
	gpen_pkg::gpen_pincfg_s rd_nxt;

	// Next values: one set written per cycle; read data is registered.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			mem_nxt[i] = mem_r[i];
		end
		if (wr_en) begin
			mem_nxt[wr_pin] = wr_data;
		end
		rd_nxt = mem_nxt[rd_pin];
	end

	// Every set is needed in parallel by the detectors, so all are also exported.
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 8; i++) begin
			if (srst) begin
				mem_r[i] <= {`GPEN_RST_CFG1, `GPEN_RST_ROUTE, `GPEN_RST_CFG2};
			end else begin
				mem_r[i] <= mem_nxt[i];
			end
		end
		if (srst) begin
			rd_r <= {`GPEN_RST_CFG1, `GPEN_RST_ROUTE, `GPEN_RST_CFG2};
		end else begin
			rd_r <= rd_nxt;
		end
	end

	assign rd_data = rd_r;
	assign all_cfg = mem_r;

endmodule // gpen_cfg_mem
`default_nettype wire

// ===== gpen_debounce.sv
/*
 * Holds the per-pin debounce filter: a level is passed on only after it
 * has been stable for the whole debounce period.
 * Assumes its input is already synchronised to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpen_cfg.svh"

module gpen_debounce #(
	parameter int unsigned DEB_CYC = `GPEN_DEB_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic din,
	output logic dout
);

	gpen_pkg::gpen_db_e st_r;
	gpen_pkg::gpen_db_e st_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic out_r;
	logic out_nxt;

	// A change restarts the count; the output follows only after a quiet period.
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		out_nxt = out_r;
		case (st_r)
			gpen_pkg::GPEN_DB_STABLE: begin
				if (din != out_r) begin
					st_nxt = gpen_pkg::GPEN_DB_COUNT;
					cnt_nxt = 32'h0000_0000;
				end
			end
			default: begin
				if (din == out_r) begin
					st_nxt = gpen_pkg::GPEN_DB_STABLE;
				end else if (cnt_r >= DEB_CYC - 1) begin
					out_nxt = din;
					st_nxt = gpen_pkg::GPEN_DB_STABLE;
				end else begin
					cnt_nxt = cnt_r + 32'h0000_0001;
				end
			end
		endcase
	end

	// Starts high so a pulled-up pin raises no false falling edge.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st_r <= gpen_pkg::GPEN_DB_STABLE;
			cnt_r <= 32'h0000_0000;
			out_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			out_r <= out_nxt;
		end
	end

	assign dout = out_r;

endmodule // gpen_debounce
`default_nettype wire

// ===== gpen_port.sv
/*
 * Holds the eight-pin event-notify port: configuration sets, runtime
 * registers, event detection and routing to interrupt and management outputs.
 * Assumes a host-side decoder delivering one-cycle config and runtime
 * strobes on clk_sys, and pad logic resolving pins from out/oe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpen_cfg.svh"

module gpen_port #(
	parameter int unsigned DEB_CYC = `GPEN_DEB_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_index,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	input wire logic rt_wr,
	input wire logic rt_rd,
	input wire logic [1:0] rt_addr,
	input wire logic [7:0] rt_wdata,
	output logic [7:0] rt_rdata,
	input wire logic block_active,
	input wire logic main_supply_ok,
	input wire logic lock_release,
	input wire logic [7:0] pin_mux_sel,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pin_pullup,
	output logic irq_out,
	output logic mgmt_interrupt_out
);

	// ****************************************
	// State.
	// ****************************************
	logic [7:0] sel_r, sel_nxt;
	logic [7:0] dout_r, dout_nxt;
	logic [7:0] even_r, even_nxt;
	logic [7:0] evst_r, evst_nxt;
	logic [7:0] sync1_r, sync2_r, prev_r;
	logic [7:0] crd_r, crd_nxt;
	logic [7:0] rrd_r, rrd_nxt;
	logic irq_r, irq_nxt, smi_r, smi_nxt;
	logic [7:0] det_lvl, act_lvl, act_edge, hit, pend;
	logic [7:0] deb_out, lock_v, vddl_v, oe_v, od_v;
	logic rt_open;
	logic cm_we;
	gpen_pkg::gpen_pincfg_s cm_wdata, cm_rdata;
	gpen_pkg::gpen_pincfg_s cfg_all [8];

	// ****************************************
	// Configuration storage.
	// ****************************************
	gpen_cfg_mem u_cfg_mem (
		.clk_sys(clk_sys),
		.srst(srst),
		.wr_pin(sel_nxt[2:0]),
		.wr_en(cm_we),
		.wr_data(cm_wdata),
		.rd_pin(sel_nxt[2:0]),
		.rd_data(cm_rdata),
		.all_cfg(cfg_all)
	);

	// Per-pin field views taken from the configuration sets.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			lock_v[i] = cfg_all[i].cfg1[`GPEN_C1_LOCK];
			vddl_v[i] = cfg_all[i].cfg2[`GPEN_C2_VDDL];
			oe_v[i] = cfg_all[i].cfg1[`GPEN_C1_OE];
			od_v[i] = cfg_all[i].cfg1[`GPEN_C1_OD];
		end
	end

	// Select register and config write; locked fields keep their old value.
	always_comb begin
		sel_nxt = sel_r;
		cm_we = 1'b0;
		cm_wdata = cm_rdata;
		if (lock_release) begin
			cm_we = 1'b1;
			cm_wdata.cfg1[`GPEN_C1_LOCK] = 1'b0;
		end
		if (cfg_wr) begin
			if (cfg_index == `GPEN_IDX_SEL) begin
				sel_nxt = {5'h00, cfg_wdata[2:0]};
				cm_we = 1'b0;
			end else if (cfg_index == `GPEN_IDX_CFG1) begin
				cm_we = 1'b1;
				if (cm_rdata.cfg1[`GPEN_C1_LOCK] && !lock_release) begin
					cm_wdata.cfg1 = {cfg_wdata[7:4], cm_rdata.cfg1[3:0]};
				end else begin
					cm_wdata.cfg1 = cfg_wdata;
				end
			end else if (cfg_index == `GPEN_IDX_ROUTE) begin
				cm_we = 1'b1;
				cm_wdata.route = cfg_wdata;
			end else if (cfg_index == `GPEN_IDX_CFG2) begin
				cm_we = 1'b1;
				if (cm_rdata.cfg1[`GPEN_C1_LOCK] && !lock_release) begin
					cm_wdata.cfg2 = {cfg_wdata[7], cm_rdata.cfg2[6:4], cfg_wdata[3:0]};
				end else begin
					cm_wdata.cfg2 = cfg_wdata;
				end
			end
		end
		if (cfg_wr && cfg_index == `GPEN_IDX_SEL) begin
			cm_we = 1'b0;
		end
	end

	// Config read data; the selected set is the one held in the read register.
	always_comb begin
		crd_nxt = 8'h00;
		if (cfg_rd) begin
			if (cfg_index == `GPEN_IDX_SEL) begin
				crd_nxt = sel_r;
			end else if (cfg_index == `GPEN_IDX_CFG1) begin
				crd_nxt = cm_rdata.cfg1;
			end else if (cfg_index == `GPEN_IDX_ROUTE) begin
				crd_nxt = cm_rdata.route;
			end else if (cfg_index == `GPEN_IDX_CFG2) begin
				crd_nxt = cm_rdata.cfg2;
			end
		end
	end

	// ****************************************
	// Pin input path.
	// ****************************************
	// Two flops guard against metastability from the asynchronous pins.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sync1_r <= 8'hFF;
			sync2_r <= 8'hFF;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	for (genvar g = 0; g < 8; g++) begin : g_deb
		gpen_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
			.clk_sys(clk_sys),
			.srst(srst),
			.din(sync2_r[g]),
			.dout(deb_out[g])
		);
	end

	// Detection: edges compare against the previous detector level.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			det_lvl[i] = cfg_all[i].cfg1[`GPEN_C1_DEB] ? deb_out[i] : sync2_r[i];
			act_lvl[i] = (det_lvl[i] == cfg_all[i].cfg1[`GPEN_C1_POL]);
			act_edge[i] = act_lvl[i] && (prev_r[i] != det_lvl[i]);
			hit[i] = cfg_all[i].cfg1[`GPEN_C1_LEVEL] ? act_lvl[i] : act_edge[i];
		end
	end

	// ****************************************
	// Runtime registers.
	// ****************************************
	// Enable and status are sealed off only when inactive and unpowered.
	assign rt_open = block_active || main_supply_ok;

	// Set beats clear, so a held active level re-sets status at once.
	always_comb begin
		dout_nxt = dout_r;
		even_nxt = even_r;
		evst_nxt = evst_r;
		if (rt_wr && rt_addr == `GPEN_RT_DOUT && block_active) begin
			dout_nxt = (rt_wdata & ~lock_v) | (dout_r & lock_v);
		end
		if (rt_wr && rt_addr == `GPEN_RT_EVEN && rt_open) begin
			even_nxt = rt_wdata;
		end
		if (rt_wr && rt_addr == `GPEN_RT_EVST && rt_open) begin
			evst_nxt = evst_r & ~rt_wdata;
		end
		evst_nxt = evst_nxt | hit;
		if (!main_supply_ok) begin
			evst_nxt = evst_nxt & ~vddl_v;
		end
	end

	// Runtime read mux; data-in shows the live synchronised pins.
	always_comb begin
		rrd_nxt = 8'h00;
		if (rt_rd) begin
			if (rt_addr == `GPEN_RT_DOUT && block_active) begin
				rrd_nxt = dout_r;
			end else if (rt_addr == `GPEN_RT_DIN && block_active) begin
				rrd_nxt = sync2_r;
			end else if (rt_addr == `GPEN_RT_EVEN && rt_open) begin
				rrd_nxt = even_r;
			end else if (rt_addr == `GPEN_RT_EVST && rt_open) begin
				rrd_nxt = evst_r;
			end
		end
	end

	// ****************************************
	// Notification.
	// ****************************************
	// Software writes reach here only via the real pin level.
	always_comb begin
		irq_nxt = 1'b0;
		smi_nxt = 1'b0;
		for (int i = 0; i < 8; i++) begin
			pend[i] = evst_r[i] && even_r[i];
			if (pend[i] && cfg_all[i].route[`GPEN_RT_IRQ] && block_active && main_supply_ok) begin
				irq_nxt = 1'b1;
			end
			if (pend[i] && cfg_all[i].route[`GPEN_RT_SMI] && (main_supply_ok || !vddl_v[i])) begin
				smi_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sel_r <= `GPEN_RST_SEL;
			dout_r <= `GPEN_RST_DOUT;
			even_r <= `GPEN_RST_EVEN;
			evst_r <= `GPEN_RST_EVST;
			prev_r <= 8'hFF;
			crd_r <= 8'h00;
			rrd_r <= 8'h00;
			irq_r <= 1'b0;
			smi_r <= 1'b0;
		end else begin
			sel_r <= sel_nxt;
			dout_r <= dout_nxt;
			even_r <= even_nxt;
			evst_r <= evst_nxt;
			prev_r <= det_lvl;
			crd_r <= crd_nxt;
			rrd_r <= rrd_nxt;
			irq_r <= irq_nxt;
			smi_r <= smi_nxt;
		end
	end

	// Pad drive: open-drain releases on one; supply-loaded pins float unpowered.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_out[i] = dout_r[i];
			pin_oe[i] = oe_v[i] && pin_mux_sel[i] && !(od_v[i] && dout_r[i])
				&& (main_supply_ok || !vddl_v[i]);
			pin_pullup[i] = cfg_all[i].cfg1[`GPEN_C1_PU] && (main_supply_ok || !vddl_v[i]);
		end
	end

	assign cfg_rdata = crd_r;
	assign rt_rdata = rrd_r;
	assign irq_out = irq_r;
	assign mgmt_interrupt_out = smi_r;

	// ****************************************
	// Checks.
	// ****************************************
	chk_pend_irq: assert property (@(posedge clk_sys) disable iff (srst)
		(|(evst_r & even_r & {cfg_all[7].route[0], cfg_all[6].route[0], cfg_all[5].route[0],
		cfg_all[4].route[0], cfg_all[3].route[0], cfg_all[2].route[0], cfg_all[1].route[0],
		cfg_all[0].route[0]}) && block_active && main_supply_ok) |=> irq_out)
		else $error("irq not raised for pending routed pin");
	chk_irq_gate: assert property (@(posedge clk_sys) disable iff (srst)
		(!block_active || !main_supply_ok) |=> !irq_out)
		else $error("irq asserted while gated");
	chk_smi_none: assert property (@(posedge clk_sys) disable iff (srst)
		((evst_r & even_r) == 8'h00) |=> !mgmt_interrupt_out)
		else $error("mgmt interrupt without pending pin");
	chk_w1c_clear: assert property (@(posedge clk_sys) disable iff (srst)
		(rt_wr && rt_addr == `GPEN_RT_EVST && rt_open && rt_wdata[0] && !hit[0] && main_supply_ok)
		|=> !evst_r[0])
		else $error("status bit not cleared by write one");
	chk_status_set: assert property (@(posedge clk_sys) disable iff (srst)
		hit[0] && (main_supply_ok || !vddl_v[0]) |=> evst_r[0])
		else $error("status not set on active event");
	chk_w0_keep: assert property (@(posedge clk_sys) disable iff (srst)
		(evst_r[1] && main_supply_ok && !(rt_wr && rt_addr == `GPEN_RT_EVST && rt_wdata[1])) |=> evst_r[1])
		else $error("status bit lost without clear");
	chk_lock_dout: assert property (@(posedge clk_sys) disable iff (srst)
		(|lock_v) |=> (((dout_r ^ $past(dout_r)) & $past(lock_v)) == 8'h00))
		else $error("locked data-out bit changed");
	chk_vdd_clear: assert property (@(posedge clk_sys) disable iff (srst)
		!main_supply_ok |=> ((evst_r & $past(vddl_v)) == 8'h00))
		else $error("supply-loaded status survived power loss");

endmodule // gpen_port
`default_nettype wire

// ===== gpen_pin_model.sv
/*
 * Holds a model of the circuitry outside the eight port pins.
 * Assumes the bench steers the outside drive levels and enables.
 */
`timescale 1ns/1ps
`default_nettype none

module gpen_pin_model (
	input wire logic clk_sys,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	output logic [7:0] pin_lvl
);
	logic [7:0] last_r;

	// ****************************************
	// Wire resolution.
	// ****************************************
	// An undriven pin without pull-up flips each cycle, so a stale level never passes.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i]) begin
				pin_lvl[i] = pin_out[i]; // The outside yields while the port drives.
			end else if (ext_en[i]) begin
				pin_lvl[i] = ext_val[i];
			end else if (pin_pullup[i]) begin
				pin_lvl[i] = 1'b1;
			end else begin
				pin_lvl[i] = ~last_r[i];
			end
		end
	end

	// Remembers the last wire level for the floating case.
	always_ff @(posedge clk_sys) begin
		last_r <= pin_lvl;
	end
endmodule // gpen_pin_model

`default_nettype wire

// ===== gpio_event_notify_port_test.sv
/*
 * Holds the self-checking bench of the event-notify port.
 * Assumes the port and the pin model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module gpio_event_notify_port_test;
	logic clk_sys = 1'b0, srst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, rt_wr = 1'b0, rt_rd = 1'b0;
	logic block_active = 1'b1, main_supply_ok = 1'b1, lock_release = 1'b0;
	logic [7:0] cfg_index = 8'h00, cfg_wdata = 8'h00, rt_wdata = 8'h00, ext_val = 8'hFF, ext_en = 8'hFF;
	logic [1:0] rt_addr = 2'h0;
	logic [7:0] pin_mux_sel = 8'hFF;
	logic [7:0] cfg_rdata, rt_rdata, pin_out, pin_oe, pin_pullup, pin_lvl;
	logic irq_out, mgmt_interrupt_out;
	int fail_count = 0, total_checks = 0;

	// ****************************************
	// Design and pin model.
	// ****************************************
	// A short debounce keeps the run brief; expectations use the same count.
	gpen_port #(.DEB_CYC(8)) u_dut (.clk_sys(clk_sys), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .rt_wr(rt_wr),
		.rt_rd(rt_rd), .rt_addr(rt_addr), .rt_wdata(rt_wdata), .rt_rdata(rt_rdata),
		.block_active(block_active), .main_supply_ok(main_supply_ok), .lock_release(lock_release),
		.pin_mux_sel(pin_mux_sel), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .irq_out(irq_out), .mgmt_interrupt_out(mgmt_interrupt_out));
	gpen_pin_model u_pins (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_lvl));

	// ****************************************
	// Shared tasks.
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic cw(input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk_sys);
		cfg_wr <= 1'b1;
		cfg_index <= idx;
		cfg_wdata <= d;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
	endtask
	task automatic cchk(input logic [7:0] idx, input logic [7:0] exp);
		@(posedge clk_sys);
		cfg_rd <= 1'b1;
		cfg_index <= idx;
		@(posedge clk_sys);
		cfg_rd <= 1'b0;
		#1;
		chk(cfg_rdata, exp);
	endtask
	task automatic rw(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		rt_wr <= 1'b1;
		rt_addr <= a;
		rt_wdata <= d;
		@(posedge clk_sys);
		rt_wr <= 1'b0;
	endtask
	task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		rt_rd <= 1'b1;
		rt_addr <= a;
		@(posedge clk_sys);
		rt_rd <= 1'b0;
		#1;
		chk(rt_rdata, exp);
	endtask
	task automatic pin(input int i, input logic v, input int n);
		@(posedge clk_sys);
		ext_val[i] <= v;
		cyc(n);
	endtask
	task automatic pwr(input logic act, input logic sup);
		@(posedge clk_sys);
		block_active <= act;
		main_supply_ok <= sup;
		cyc(3);
	endtask
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios.
	// ****************************************
	task automatic t_reset();
		cchk(8'hF0, 8'h00);
		cchk(8'hF2, 8'h01);
		cchk(8'hF3, 8'h00);
		cchk(8'hF8, 8'h00);
		rchk(2'h0, 8'hFF);
		rchk(2'h3, 8'h00);
		rchk(2'h1, 8'hFF);
		cw(8'hF0, 8'h05);
		cw(8'hF2, 8'h03);
		cw(8'hF1, 8'h04);
		cyc(1);
		chk(pin_pullup, 8'h20);
		cw(8'hF0, 8'h06);
		cchk(8'hF2, 8'h01);
		cw(8'hF0, 8'h05);
		cchk(8'hF2, 8'h03);
		cw(8'hF2, 8'h01);
		cw(8'hF1, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_edge();
		cw(8'hF0, 8'h00);
		cw(8'hF1, 8'h20);
		pin(0, 1'b0, 6);
		rchk(2'h3, 8'h00);
		pin(0, 1'b1, 6);
		rchk(2'h3, 8'h01);
		chk({7'h00, irq_out}, 8'h00);
		rw(2'h3, 8'hFE);
		rchk(2'h3, 8'h01);
		rw(2'h2, 8'h01);
		cyc(2);
		chk({6'h00, mgmt_interrupt_out, irq_out}, 8'h01);
		rw(2'h3, 8'h01);
		cyc(2);
		chk({6'h00, mgmt_interrupt_out, irq_out}, 8'h00);
		rw(2'h2, 8'h00);
		$display("test edge done");
	endtask
	task automatic t_level();
		cw(8'hF0, 8'h01);
		cw(8'hF1, 8'h10);
		cw(8'hF2, 8'h02);
		pin(1, 1'b0, 6);
		rw(2'h3, 8'h02);
		rchk(2'h3, 8'h02);
		rw(2'h2, 8'h02);
		pwr(1'b1, 1'b0);
		chk({6'h00, mgmt_interrupt_out, irq_out}, 8'h02);
		cw(8'hF3, 8'h10);
		cyc(3);
		rchk(2'h3, 8'h00);
		chk({6'h00, mgmt_interrupt_out, irq_out}, 8'h00);
		pwr(1'b1, 1'b1);
		pin(1, 1'b1, 1);
		cw(8'hF3, 8'h00);
		cw(8'hF1, 8'h00);
		cyc(4);
		rw(2'h3, 8'h02);
		rw(2'h2, 8'h00);
		$display("test level done");
	endtask
	task automatic t_gate();
		cw(8'hF0, 8'h02);
		cw(8'hF1, 8'h30);
		rw(2'h2, 8'h04);
		cyc(6);
		chk({7'h00, irq_out}, 8'h01);
		pwr(1'b1, 1'b0);
		chk({7'h00, irq_out}, 8'h00);
		pwr(1'b0, 1'b1);
		chk({7'h00, irq_out}, 8'h00);
		pwr(1'b0, 1'b0);
		rw(2'h2, 8'hFF);
		rchk(2'h2, 8'h00);
		chk({7'h00, irq_out}, 8'h00);
		pwr(1'b1, 1'b1);
		rchk(2'h2, 8'h04);
		cw(8'hF1, 8'h00);
		rw(2'h3, 8'h04);
		rw(2'h2, 8'h00);
		rchk(2'h3, 8'h00);
		$display("test gate done");
	endtask
	task automatic t_soft();
		cw(8'hF0, 8'h03);
		cw(8'hF1, 8'h01);
		rw(2'h2, 8'h08);
		rw(2'h0, 8'hF7);
		cyc(6);
		chk(pin_oe & 8'h08, 8'h08);
		rchk(2'h3, 8'h08);
		chk({7'h00, irq_out}, 8'h01);
		rw(2'h1, 8'h00);
		rchk(2'h1, 8'hF7);
		cw(8'hF1, 8'h09);
		rw(2'h0, 8'hFF);
		rchk(2'h0, 8'hF7);
		cw(8'hF1, 8'h00);
		cchk(8'hF1, 8'h09);
		cw(8'hF3, 8'h70);
		cchk(8'hF3, 8'h00);
		@(posedge clk_sys);
		lock_release <= 1'b1;
		@(posedge clk_sys);
		lock_release <= 1'b0;
		cw(8'hF1, 8'h03);
		cchk(8'hF1, 8'h03);
		cyc(1);
		chk(pin_oe & 8'h08, 8'h08);
		@(posedge clk_sys);
		pin_mux_sel <= 8'hF7;
		cyc(1);
		chk(pin_oe & 8'h08, 8'h00);
		@(posedge clk_sys);
		pin_mux_sel <= 8'hFF;
		rw(2'h0, 8'hFF);
		cyc(1);
		chk(pin_oe & 8'h08, 8'h00);
		cw(8'hF1, 8'h00);
		rw(2'h3, 8'h08);
		rw(2'h2, 8'h00);
		$display("test soft done");
	endtask
	task automatic t_deb();
		cw(8'hF0, 8'h04);
		cw(8'hF1, 8'h60);
		pin(4, 1'b0, 30);
		rw(2'h3, 8'h10);
		pin(4, 1'b1, 3);
		pin(4, 1'b0, 20);
		rchk(2'h3, 8'h00);
		pin(4, 1'b1, 5);
		rchk(2'h3, 8'h00);
		cyc(20);
		rchk(2'h3, 8'h10);
		cw(8'hF1, 8'h00);
		rw(2'h3, 8'h10);
		$display("test debounce done");
	endtask

	// ****************************************
	// Clock, sequence and watchdog.
	// ****************************************
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	// Reset spans four cycles, then each scenario runs in turn.
	initial begin
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		cyc(1);
		chk(pin_out, 8'hFF);
		t_reset();
		t_edge();
		t_level();
		t_gate();
		t_soft();
		t_deb();
		wrap_up();
	end

	// A hung run counts as a mismatch and still gets its verdict.
	initial begin
		#400000;
		fail_count++;
		wrap_up();
	end
endmodule // gpio_event_notify_port_test

`default_nettype wire
